// *** core/fbpc_regs.vh ***
// Register map, command codes and sequence addresses of the flash protection controller
`ifndef FBPC_REGS_VH
`define FBPC_REGS_VH
`define FBPC_OFF_CTRL      12'h000
`define FBPC_OFF_ADDR      12'h004
`define FBPC_OFF_DATA      12'h008
`define FBPC_OFF_PWLO      12'h00c
`define FBPC_OFF_PWHI      12'h010
`define FBPC_OFF_STAT      12'h014
`define FBPC_OFF_RDATA     12'h018
`define FBPC_CTRL_GO       0
`define FBPC_CTRL_OP_LSB   4
`define FBPC_CTRL_X16      8
`define FBPC_STAT_BUSY     0
`define FBPC_STAT_PROT     1
`define FBPC_OP_PROG_LOCK  4'h0
`define FBPC_OP_PROG_PW    4'h1
`define FBPC_OP_UNLOCK_PW  4'h2
`define FBPC_OP_PROT_NV    4'h3
`define FBPC_OP_CLR_NV     4'h4
`define FBPC_OP_READ_NV    4'h5
`define FBPC_OP_SET_VOL    4'h6
`define FBPC_OP_CLR_VOL    4'h7
`define FBPC_OP_READ_VOL   4'h8
`define FBPC_OP_READ_LOCK  4'h9
`define FBPC_OP_READ_PW    4'ha
`define FBPC_SET_LOCK      8'h40
`define FBPC_SET_PW        8'h60
`define FBPC_SET_NV        8'hc0
`define FBPC_SET_VOL       8'he0
`define FBPC_CMD_AA        8'haa
`define FBPC_CMD_55        8'h55
`define FBPC_CMD_PROG      8'ha0
`define FBPC_CMD_ERASE     8'h80
`define FBPC_CMD_ERCONF    8'h30
`define FBPC_CMD_EXIT      8'h90
`define FBPC_CMD_UNL1      8'h25
`define FBPC_CMD_UNL2      8'h03
`define FBPC_CMD_UNLEND    8'h29
`define FBPC_ADR_X8_A      24'haaa
`define FBPC_ADR_X8_B      24'h555
`define FBPC_ADR_X16_A     24'h555
`define FBPC_ADR_X16_B     24'h2aa
`define FBPC_T_CYC_NS      50
`define FBPC_CLK_NS        25
`define FBPC_T_CYC_CLK     ((`FBPC_T_CYC_NS + `FBPC_CLK_NS - 1) / `FBPC_CLK_NS)
`endif

// *** core/fbpc_host.v ***
// Host controller that drives flash block protection command sequences
//
// Design decisions made here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "fbpc_regs.vh"
module fbpc_host (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg  [23:0] flash_addr,
  output reg  [15:0] flash_dq_out,
  output reg         flash_dq_oe_n,
  input  wire [15:0] flash_dq_in,
  output reg         flash_ce_n,
  output reg         flash_we_n,
  output reg         flash_oe_n
);
  localparam ST_IDLE = 3'd0;
  localparam ST_SET  = 3'd1;
  localparam ST_WR   = 3'd2;
  localparam ST_RD   = 3'd3;
  localparam ST_NEXT = 3'd4;
  localparam ST_GAP  = 3'd5;
  // Strobe and gap length in clocks, cut to the timer width on use
  localparam integer T_CYC = `FBPC_T_CYC_CLK;

  reg [2:0]  state_reg;
  reg [3:0]  op_reg;
  reg        x16_reg;
  reg [23:0] addr_reg;
  reg [15:0] data_reg;
  reg [63:0] pw_reg;
  reg [31:0] rdata_reg;
  reg        prot_reg;
  reg [4:0]  step_reg;
  reg [3:0]  tmr_reg;
  reg        cyc_rd;
  reg [23:0] cyc_a;
  reg [15:0] cyc_d;
  reg        cyc_last;
  reg [4:0]  n_pw;

  wire       acc = psel & penable;

  // Password chunk count per bus width
  function [4:0] pw_chunks;
    input x16;
    begin
      pw_chunks = x16 ? 5'd4 : 5'd8;
    end
  endfunction

  // Set code that opens the command set of an operation
  function [7:0] set_code;
    input [3:0] op;
    begin
      case (op)
        `FBPC_OP_PROG_LOCK, `FBPC_OP_READ_LOCK: set_code = `FBPC_SET_LOCK;
        `FBPC_OP_PROG_PW, `FBPC_OP_UNLOCK_PW, `FBPC_OP_READ_PW: set_code = `FBPC_SET_PW;
        `FBPC_OP_SET_VOL, `FBPC_OP_CLR_VOL, `FBPC_OP_READ_VOL: set_code = `FBPC_SET_VOL;
        default: set_code = `FBPC_SET_NV;
      endcase
    end
  endfunction

  // Password chunk of a given index, byte or word
  function [15:0] pw_chunk;
    input [63:0] pw;
    input        x16;
    input [2:0]  idx;
    begin
      if (x16)
        pw_chunk = pw[{idx[1:0], 4'h0} +: 16];
      else
        pw_chunk = {8'h00, pw[{idx, 3'h0} +: 8]};
    end
  endfunction

  // Cycle table: three entry cycles, body cycles, then exit pair
  always @* begin
    cyc_rd   = 1'b0;
    cyc_a    = 24'h000000;
    cyc_d    = 16'h0000;
    cyc_last = 1'b0;
    n_pw     = pw_chunks(x16_reg);
    case (step_reg)
      5'd0: begin
        cyc_a = x16_reg ? `FBPC_ADR_X16_A : `FBPC_ADR_X8_A;
        cyc_d = {8'h00, `FBPC_CMD_AA};
      end
      5'd1: begin
        cyc_a = x16_reg ? `FBPC_ADR_X16_B : `FBPC_ADR_X8_B;
        cyc_d = {8'h00, `FBPC_CMD_55};
      end
      5'd2: begin
        cyc_a = x16_reg ? `FBPC_ADR_X16_A : `FBPC_ADR_X8_A;
        cyc_d = {8'h00, set_code(op_reg)};
      end
      default: begin
        case (op_reg)
          `FBPC_OP_PROG_LOCK, `FBPC_OP_PROG_PW: begin
            if (step_reg == 5'd3) begin
              cyc_d = {8'h00, `FBPC_CMD_PROG};
            end else begin
              cyc_a = (op_reg == `FBPC_OP_PROG_PW) ? addr_reg : 24'h000000;
              cyc_d = data_reg;
              cyc_last = 1'b1;
            end
          end
          `FBPC_OP_PROT_NV, `FBPC_OP_SET_VOL, `FBPC_OP_CLR_VOL: begin
            if (step_reg == 5'd3) begin
              cyc_d = {8'h00, `FBPC_CMD_PROG};
            end else begin
              cyc_a = addr_reg;
              cyc_d = (op_reg == `FBPC_OP_CLR_VOL) ? 16'h0001 : 16'h0000;
              cyc_last = 1'b1;
            end
          end
          `FBPC_OP_CLR_NV: begin
            if (step_reg == 5'd3) begin
              cyc_d = {8'h00, `FBPC_CMD_ERASE};
            end else begin
              cyc_d = {8'h00, `FBPC_CMD_ERCONF};
              cyc_last = 1'b1;
            end
          end
          `FBPC_OP_UNLOCK_PW: begin
            if (step_reg == 5'd3) begin
              cyc_d = {8'h00, `FBPC_CMD_UNL1};
            end else if (step_reg == 5'd4) begin
              cyc_d = {8'h00, `FBPC_CMD_UNL2};
            end else if (step_reg < 5'd5 + n_pw) begin
              cyc_a = {21'h000000, step_reg[2:0] - 3'd5};
              cyc_d = pw_chunk(pw_reg, x16_reg, step_reg[2:0] - 3'd5);
            end else begin
              cyc_d = {8'h00, `FBPC_CMD_UNLEND};
              cyc_last = 1'b1;
            end
          end
          `FBPC_OP_READ_PW: begin
            cyc_rd = 1'b1;
            cyc_a = addr_reg;
            cyc_last = 1'b1;
          end
          default: begin
            cyc_rd = 1'b1;
            cyc_a = addr_reg;
            cyc_last = 1'b1;
          end
        endcase
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg     <= ST_IDLE;
      op_reg        <= 4'h0;
      x16_reg       <= 1'b0;
      addr_reg      <= 24'h000000;
      data_reg      <= 16'h0000;
      pw_reg        <= 64'h0000000000000000;
      rdata_reg     <= 32'h00000000;
      prot_reg      <= 1'b0;
      step_reg      <= 5'd0;
      tmr_reg       <= 4'h0;
      prdata        <= 32'h00000000;
      pready        <= 1'b0;
      pslverr       <= 1'b0;
      flash_addr    <= 24'h000000;
      flash_dq_out  <= 16'h0000;
      flash_dq_oe_n <= 1'b1;
      flash_ce_n    <= 1'b1;
      flash_we_n    <= 1'b1;
      flash_oe_n    <= 1'b1;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        pready <= 1'b1;
        prdata <= 32'h00000000;
        case (paddr)
          `FBPC_OFF_STAT:  prdata <= {30'h0, prot_reg, state_reg != ST_IDLE};
          `FBPC_OFF_RDATA: prdata <= rdata_reg;
          `FBPC_OFF_ADDR:  prdata <= {8'h00, addr_reg};
          `FBPC_OFF_DATA:  prdata <= {16'h0000, data_reg};
          `FBPC_OFF_CTRL:  prdata <= {23'h0, x16_reg, op_reg, 4'h0};
          `FBPC_OFF_PWLO, `FBPC_OFF_PWHI: prdata <= 32'h00000000;
          default:         pslverr <= 1'b1;
        endcase
      end
      // Writes land at the access edge, where the master sees pready high
      if (acc && pready && pwrite && state_reg == ST_IDLE) begin
        case (paddr)
          `FBPC_OFF_ADDR: addr_reg <= pwdata[23:0];
          `FBPC_OFF_DATA: data_reg <= pwdata[15:0];
          `FBPC_OFF_PWLO: pw_reg[31:0] <= pwdata;
          `FBPC_OFF_PWHI: pw_reg[63:32] <= pwdata;
          `FBPC_OFF_CTRL: begin
            op_reg   <= pwdata[`FBPC_CTRL_OP_LSB +: 4];
            x16_reg  <= pwdata[`FBPC_CTRL_X16];
            if (pwdata[`FBPC_CTRL_GO]) begin
              step_reg  <= 5'd0;
              state_reg <= ST_SET;
            end
          end
          default: ;
        endcase
      end
      case (state_reg)
        ST_IDLE: ;
        ST_SET: begin
          flash_addr    <= cyc_a;
          flash_dq_out  <= cyc_d;
          flash_ce_n    <= 1'b0;
          flash_dq_oe_n <= cyc_rd;
          flash_we_n    <= cyc_rd;
          flash_oe_n    <= ~cyc_rd;
          tmr_reg       <= T_CYC[3:0];
          state_reg     <= cyc_rd ? ST_RD : ST_WR;
        end
        ST_WR, ST_RD: begin
          if (tmr_reg > 4'h1) begin
            tmr_reg <= tmr_reg - 4'h1;
          end else begin
            if (state_reg == ST_RD) begin
              rdata_reg <= {16'h0000, flash_dq_in};
              prot_reg  <= ~flash_dq_in[0];
            end
            flash_we_n    <= 1'b1;
            flash_oe_n    <= 1'b1;
            flash_ce_n    <= 1'b1;
            flash_dq_oe_n <= 1'b1;
            state_reg     <= ST_NEXT;
          end
        end
        ST_NEXT: begin
          tmr_reg <= T_CYC[3:0];
          if (step_reg[4]) begin
            state_reg <= (step_reg[0]) ? ST_IDLE : ST_GAP;
          end else if (cyc_last) begin
            step_reg  <= 5'd16;
            state_reg <= ST_GAP;
          end else begin
            step_reg  <= step_reg + 5'd1;
            state_reg <= ST_GAP;
          end
        end
        ST_GAP: begin
          if (tmr_reg > 4'h1) begin
            tmr_reg <= tmr_reg - 4'h1;
          end else begin
            flash_addr    <= 24'h000000;
            flash_dq_out  <= step_reg[4] ? (step_reg[0] ? 16'h0000 : {8'h00, `FBPC_CMD_EXIT})
                                         : cyc_d;
            flash_ce_n    <= 1'b0;
            if (step_reg[4]) begin
              flash_dq_oe_n <= 1'b0;
              flash_we_n    <= 1'b0;
              tmr_reg       <= T_CYC[3:0];
              state_reg     <= ST_WR;
            end else begin
              flash_ce_n <= 1'b1;
              state_reg  <= ST_SET;
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
      if (state_reg == ST_NEXT && step_reg[4] && !step_reg[0])
        step_reg <= 5'd17;
    end
  end
endmodule

// *** verif/fbpc_host_checker.sv ***
// Port assertions for the flash protection host controller
`timescale 1ns/1ps
module fbpc_host_checker (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pready,
  input wire        pslverr,
  input wire [23:0] flash_addr,
  input wire [15:0] flash_dq_out,
  input wire        flash_dq_oe_n,
  input wire        flash_ce_n,
  input wire        flash_we_n,
  input wire        flash_oe_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_answer: assert property (psel && !penable |=> pready) else $error("no answer");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready too long");
  a_err_with_ready: assert property (pslverr |-> pready) else $error("lone error");
  a_we_two_clocks: assert property ($fell(flash_we_n) |=> !flash_we_n ##1 flash_we_n)
    else $error("write strobe width");
  a_we_pins: assert property (!flash_we_n |-> !flash_ce_n && flash_oe_n && !flash_dq_oe_n)
    else $error("write cycle pins");
  a_read_released: assert property (!flash_oe_n |-> flash_dq_oe_n) else $error("bus clash");
  a_cycle_stable: assert property (!flash_we_n && !$fell(flash_we_n)
    |-> $stable(flash_dq_out) && $stable(flash_addr)) else $error("cycle moved");
  a_entry_addr: assert property (
    $fell(flash_we_n) && flash_dq_out[7:0] == 8'haa && flash_addr > 24'h7
    |-> flash_addr == 24'haaa || flash_addr == 24'h555) else $error("entry address");
endmodule

// *** verif/fbpc_flash_model.sv ***
// Behavioural flash device with block protection bits
`timescale 1ns/1ps
module fbpc_flash_model #(
  parameter PWM_BIT = 2
) (
  input  wire        hw_reset_n,
  input  wire        pclk,
  input  wire [23:0] flash_addr,
  input  wire [15:0] flash_dq_out,
  input  wire        flash_ce_n,
  input  wire        flash_we_n,
  input  wire        flash_oe_n,
  output wire [15:0] flash_dq_in
);
  logic [15:0] nv = 16'hffff;
  logic        pw_mode = 1'b0;
  logic [15:0] last = 16'h0;
  logic [15:0] vol, rdv;
  logic [63:0] pw, pw_in;
  logic [7:0]  set;
  logic [3:0]  st, k;
  logic        lock, w16, we_q;
  wire  [3:0]  blk = flash_addr[3:0];
  wire  [7:0]  d = flash_dq_out[7:0];
  always @(posedge pclk or negedge hw_reset_n) begin
    if (!hw_reset_n) begin
      vol  <= 16'hffff;
      lock <= !pw_mode;
      st   <= 4'h0;
      we_q <= 1'b1;
    end else begin
      we_q <= flash_we_n;
      if (we_q && !flash_we_n && !flash_ce_n) begin
        case (st)
          0: begin st <= (d == 8'haa) ? 4'h1 : 4'h0; w16 <= (flash_addr == 24'h555); end
          1: st <= (d == 8'h55) ? 4'h2 : 4'h0;
          2: begin set <= d; st <= 4'h3; end
          3: begin
            k  <= 4'h0;
            st <= (d == 8'ha0) ? 4'h4 : (d == 8'h80) ? 4'h5 : (d == 8'h90) ? 4'h6 :
                  (d == 8'h25 && set == 8'h60) ? 4'h7 : 4'h3;
          end
          4: begin
            st <= 4'h3;
            if (set == 8'h40 && !d[PWM_BIT]) pw_mode <= 1'b1;
            if (set == 8'h60 && !pw_mode && w16) pw[16*flash_addr[1:0] +: 16] <= flash_dq_out;
            if (set == 8'h60 && !pw_mode && !w16) pw[8*flash_addr[2:0] +: 8] <= d;
            if (set == 8'hc0 && lock && d == 8'h00) nv[blk] <= 1'b0;
            if (set == 8'he0) vol[blk] <= d[0];
          end
          5: begin st <= 4'h3; if (d == 8'h30 && lock) nv <= 16'hffff; end
          6: st <= 4'h0;
          7: st <= (d == 8'h03) ? 4'h8 : 4'h3;
          default: begin
            k <= k + 4'h1;
            if (k == (w16 ? 4 : 8)) begin
              st <= 4'h3;
              if (d == 8'h29 && pw_in == pw) lock <= 1'b1;
            end else if (w16) pw_in[16*flash_addr[1:0] +: 16] <= flash_dq_out;
            else pw_in[8*flash_addr[2:0] +: 8] <= d;
          end
        endcase
      end
    end
  end
  always @* begin
    case (set)
      8'h40: rdv = {13'h0, !pw_mode, 2'b11};
      8'h60: rdv = pw_mode ? 16'hffff : w16 ? pw[16*flash_addr[1:0] +: 16] :
                   {8'h0, pw[8*flash_addr[2:0] +: 8]};
      8'hc0: rdv = {15'h0, nv[blk]};
      8'he0: rdv = {15'h0, vol[blk]};
      default: rdv = 16'h0;
    endcase
    if (st < 4'h3) rdv = {15'h0, ~(nv[blk] & vol[blk])};
  end
  always @(posedge pclk) if (!flash_oe_n && !flash_ce_n) last <= rdv;
  // Released bus shows inverse of the last value
  assign flash_dq_in = (!flash_oe_n && !flash_ce_n) ? rdv : ~last;
endmodule

// *** verif/fbpc_host_bench.sv ***
// Self-checking bench for the flash protection host controller
`timescale 1ns/1ps
`include "fbpc_regs.vh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("mismatch at %0t got %0h exp %0h", $time, g, e); end end
module fbpc_host_bench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, w;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [23:0] flash_addr;
  logic [15:0] flash_dq_out, flash_dq_in;
  logic        flash_dq_oe_n, flash_ce_n, flash_we_n, flash_oe_n;
  logic [63:0] pw;
  logic [3:0]  b, c, i;
  int          fail_count, num_checks;
  fbpc_host i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
    .flash_dq_oe_n(flash_dq_oe_n), .flash_dq_in(flash_dq_in), .flash_ce_n(flash_ce_n),
    .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n));
  fbpc_flash_model i_dev (.hw_reset_n(presetn), .pclk(pclk), .flash_addr(flash_addr),
    .flash_dq_out(flash_dq_out), .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n),
    .flash_oe_n(flash_oe_n), .flash_dq_in(flash_dq_in));
  function automatic logic [7:0] chunk(input logic [63:0] p, input logic [3:0] n);
    return p[8*n[2:0] +: 8];
  endfunction
  task automatic finish_test();
    if (fail_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin fail_count++; finish_test(); end
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic run(input logic [3:0] op, input logic x, input logic [3:0] a,
                     input logic [31:0] d);
    int n;
    apb(1'b1, `FBPC_OFF_ADDR, {28'h0, a});
    apb(1'b1, `FBPC_OFF_DATA, d);
    apb(1'b1, `FBPC_OFF_CTRL, {23'h0, x, op, 4'h1});
    n = 0;
    do begin apb(1'b0, `FBPC_OFF_STAT, 0); n++; end while (rd[0] !== 1'b0 && n < 400);
    if (rd[0] !== 1'b0) begin fail_count++; finish_test(); end
  endtask
  task automatic setpw(input logic [63:0] p);
    apb(1'b1, `FBPC_OFF_PWLO, p[31:0]);
    apb(1'b1, `FBPC_OFF_PWHI, p[63:32]);
  endtask
  task automatic hw_reset();
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    fail_count = 0;
    num_checks = 0;
    void'($urandom(92));
    hw_reset();
    apb(1'b0, 12'h01c, 0);
    `CHK(err, 1'b1)
    // Random blocks and bus widths, neighbour untouched
    repeat (4) begin
      b = 4'($urandom);
      w = 1'($urandom);
      c = b + 4'h1;
      run(`FBPC_OP_SET_VOL, w, b, 0);
      run(`FBPC_OP_READ_VOL, !w, b, 0);
      `CHK(rd[1], 1'b1)
      run(`FBPC_OP_READ_VOL, w, c, 0);
      `CHK(rd[1], 1'b0)
      run(`FBPC_OP_CLR_VOL, w, b, 0);
      run(`FBPC_OP_READ_VOL, w, b, 0);
      `CHK(rd[1], 1'b0)
    end
    run(`FBPC_OP_PROT_NV, 1'b0, b, 0);
    run(`FBPC_OP_PROT_NV, 1'b1, c, 0);
    run(`FBPC_OP_READ_NV, 1'b0, c, 0);
    `CHK(rd[1], 1'b1)
    run(`FBPC_OP_CLR_NV, 1'b0, 0, 0);
    run(`FBPC_OP_READ_NV, 1'b0, b, 0);
    `CHK(rd[1], 1'b0)
    pw = {$urandom, $urandom};
    i = 4'($urandom_range(7));
    setpw(pw);
    // One program command per password byte, at its own index
    for (int k = 0; k < 8; k++)
      run(`FBPC_OP_PROG_PW, 1'b0, 4'(k), {24'h0, chunk(pw, 4'(k))});
    run(`FBPC_OP_READ_PW, 1'b0, i, 0);
    apb(1'b0, `FBPC_OFF_RDATA, 0);
    `CHK(rd[7:0], chunk(pw, i))
    run(`FBPC_OP_SET_VOL, 1'b0, b, 0);
    run(`FBPC_OP_PROG_LOCK, 1'b0, 0, 32'hfffb);
    run(`FBPC_OP_READ_LOCK, 1'b0, 0, 0);
    apb(1'b0, `FBPC_OFF_RDATA, 0);
    `CHK(rd[2], 1'b0)
    // Stored password can no longer be read or replaced
    setpw(~pw);
    run(`FBPC_OP_PROG_PW, 1'b0, i, {24'h0, ~chunk(pw, i)});
    run(`FBPC_OP_READ_PW, 1'b0, i, 0);
    apb(1'b0, `FBPC_OFF_RDATA, 0);
    `CHK(rd[7:0], 8'hff)
    hw_reset();
    run(`FBPC_OP_READ_VOL, 1'b0, b, 0);
    `CHK(rd[1], 1'b0)
    run(`FBPC_OP_PROT_NV, 1'b0, b, 0);
    run(`FBPC_OP_READ_NV, 1'b0, b, 0);
    `CHK(rd[1], 1'b0)
    run(`FBPC_OP_UNLOCK_PW, 1'b0, 0, 0);
    run(`FBPC_OP_PROT_NV, 1'b0, b, 0);
    run(`FBPC_OP_READ_NV, 1'b0, b, 0);
    `CHK(rd[1], 1'b0)
    setpw(pw);
    run(`FBPC_OP_UNLOCK_PW, 1'b0, 0, 0);
    run(`FBPC_OP_PROT_NV, 1'b0, b, 0);
    run(`FBPC_OP_READ_NV, 1'b0, b, 0);
    `CHK(rd[1], 1'b1)
    finish_test();
  end
endmodule
bind fbpc_host fbpc_host_checker i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .flash_addr(flash_addr),
  .flash_dq_out(flash_dq_out), .flash_dq_oe_n(flash_dq_oe_n), .flash_ce_n(flash_ce_n),
  .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n));
